//--- core/vsv_regs.svh
// register offsets, setting fields, reset values and timing counts
`ifndef VSV_REGS_SVH
`define VSV_REGS_SVH
`define VSV_CTRL_OFS 8'h00
`define VSV_STAT_OFS 8'h04
`define VSV_CNT0_OFS 8'h08
`define VSV_CNT1_OFS 8'h0c
`define VSV_RAT0_OFS 8'h10
`define VSV_RAT1_OFS 8'h14
`define VSV_PREF_OFS 8'h18
`define VSV_TREM_OFS 8'h1c
`define VSV_SET_TAG 2'h1
`define VSV_CTRL_CLR 0
`define VSV_CTRL_FORCE 1
`define VSV_SET0_RST 32'h0b0ca805
`define VSV_SET1_RST 32'h00000014
`define VSV_THR_SCALE 16'h000a
`define VSV_ANG_FULL 12'he10
`define VSV_ANG_HALF 12'h708
`define VSV_CLK_NS 5
`define VSV_MS_NS 1000000
`define VSV_MS_CYCLES (`VSV_MS_NS / `VSV_CLK_NS)
`endif

//--- core/vsv_pkg.sv
// types shared by the vt supervision design
package vsv_pkg;
  typedef struct packed {
    logic [2:0][15:0] ph_rms;
    logic [2:0][15:0] ll_rms;
    logic [15:0] positive_seq_voltage;
    logic [15:0] negative_seq_voltage;
    logic [15:0] zero_seq_voltage;
    logic [2:0][11:0] ph_ang;
    logic [2:0][11:0] ll_ang;
  } vsv_meas_t;
  typedef struct packed {
    logic enable;
    logic ch_line;
    logic line_chk;
    logic bus_chk;
    logic [9:0] ang_lim;
    logic [6:0] high_thr;
    logic [6:0] low_thr;
  } vsv_cfg_t;
  typedef struct packed {
    logic blocked;
    logic line_alarm;
    logic bus_alarm;
    logic start;
  } vsv_outs_t;
  typedef struct packed {
    logic [31:0] stamp_ms;
    logic [3:0] rise;
    logic [3:0] fall;
  } vsv_event_t;
  typedef enum logic [2:0] {COND_NORMAL, COND_START, COND_LINE, COND_BUS, COND_BLOCKED} vsv_cond_t;
  typedef enum logic [2:0] {BUS_DEAD, BUS_OK, BUS_REV, BUS_UNDEF, BUS_PROBLEM} vsv_bus_t;
  typedef enum logic [1:0] {T_IDLE, T_RUN, T_ALARM} vsv_tmr_t;
endpackage

//--- core/vsv_setmem.sv
// eight setting groups, two words each, with registered read ports
`timescale 1ns/1ps
`include "vsv_regs.svh"
module vsv_setmem (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [1:0] i_we,
  input wire logic [2:0] i_waddr,
  input wire logic [31:0] i_wdata,
  input wire logic [2:0] i_raddr_a,
  output logic [63:0] o_rdata_a,
  input wire logic [2:0] i_raddr_b,
  output logic [63:0] o_rdata_b
);
  logic [63:0] mem_r [8];
  logic [63:0] merged;

  // word as it stands after the pending write
  always_comb begin
    merged = mem_r[i_waddr];
    if (i_we[0]) merged[31:0] = i_wdata;
    if (i_we[1]) merged[63:32] = i_wdata;
  end

  ////////////////////////////////////////////////////////////////
  // storage, every group resets to the default settings
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int g = 0; g < 8; g++) begin
        mem_r[g] <= {`VSV_SET1_RST, `VSV_SET0_RST};
      end
    end else if (|i_we) begin
      mem_r[i_waddr] <= merged;
    end
  end

  // read ports bypass a write to the same group
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata_a <= 64'h0;
      o_rdata_b <= 64'h0;
    end else begin
      o_rdata_a <= (|i_we && i_waddr == i_raddr_a) ? merged : mem_r[i_raddr_a];
      o_rdata_b <= (|i_we && i_waddr == i_raddr_b) ? merged : mem_r[i_raddr_b];
    end
  end
endmodule

//--- core/vsv_events.sv
// output edge events with millisecond stamp and cumulative counters
`timescale 1ns/1ps
`include "vsv_regs.svh"
module vsv_events #(
  parameter int MS_CYCLES = `VSV_MS_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire vsv_pkg::vsv_outs_t i_outs,
  input wire logic i_cnt_clr,
  output logic o_evt_valid,
  output vsv_pkg::vsv_event_t o_evt,
  output logic [3:0][15:0] o_cnt
);
  logic [17:0] div_r;
  logic [31:0] stamp_r;
  logic [3:0] prev_r;
  logic [3:0] rise;
  logic [3:0] fall;

  assign rise = i_outs & ~prev_r;
  assign fall = ~i_outs & prev_r;

  ////////////////////////////////////////////////////////////////
  // millisecond time base
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_r <= 18'h0;
      stamp_r <= 32'h0;
    end else if (div_r == 18'(MS_CYCLES - 1)) begin
      div_r <= 18'h0;
      stamp_r <= stamp_r + 32'h1;
    end else begin
      div_r <= div_r + 18'h1;
    end
  end

  // one event word carries every edge of the cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prev_r <= 4'h0;
      o_evt_valid <= 1'b0;
      o_evt <= '0;
    end else begin
      prev_r <= i_outs;
      o_evt_valid <= |(rise | fall);
      o_evt <= '{stamp_ms: stamp_r, rise: rise, fall: fall};
    end
  end

  // counters, an occurrence in the clear cycle still counts
  for (genvar k = 0; k < 4; k++) begin : g_cnt
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        o_cnt[k] <= 16'h0;
      end else if (i_cnt_clr) begin
        o_cnt[k] <= {15'h0, rise[k]};
      end else if (rise[k]) begin
        o_cnt[k] <= o_cnt[k] + 16'h1;
      end
    end
  end
endmodule

//--- core/vsv_top.sv
// vt supervision: ahb-lite registers, pick-up, blocking, timer, state
//
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "vsv_regs.svh"
// Behaviour
// - eight setting groups, active one picked by a common selector, incl. mode.
// - outputs start, bus alarm, line alarm and blocked.
// - every edge of each output emits an event stamped in milliseconds.
// - cumulative counts of each output occurrence, clearable by software.
// - rms, sequence and angle inputs refreshed each 5 ms tick.
// - channel set from a setting; pre-fault is 20 ms average ending 15 ms early.
// - pick-up when any phase below low or two above high threshold.
// - per-phase ratio of threshold setting to measured magnitude.
// - thresholds in 0.01 nominal steps, defaults 0.05 and 0.80.
// - angle change over 40 ms below limit blocks pick-up; 0.1 deg, default 5.
// - bus fuse check enable, default on, supervises bus breaker trip.
// - line fuse check enable, default on, supervises feeder breaker trip.
// - start only when pick-up active and no blocking.
// - fuse-trip pick-up acts in the cycle the input asserts.
// - bus state dead, live ok, live reversed or live undefined sequence.
// - problem state wins over healthy live states while pick-up holds.
// - block sampled every cycle; blocked replaces start and resets start.
// - condition code 0 normal, 1 start, 2 line, 3 bus, 4 blocked.
module vsv_top #(
  parameter int MS_CYCLES = `VSV_MS_CYCLES
) (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  input wire logic I_MEAS_TICK,
  input wire vsv_pkg::vsv_meas_t I_MEAS,
  input wire logic [2:0] I_GROUP_SEL,
  input wire logic I_BLOCK,
  input wire logic I_BUS_BREAKER_TRIP_INPUT,
  input wire logic I_FEEDER_BREAKER_TRIP_INPUT,
  output logic O_START,
  output logic O_BUS_ALARM,
  output logic O_LINE_ALARM,
  output logic O_BLOCKED,
  output logic O_EVT_VALID,
  output vsv_pkg::vsv_event_t O_EVT,
  output logic [2:0] O_CONDITION,
  output logic [2:0] O_BUS_STATE
);
  // true for the setting window of the map
  function automatic logic is_set(input logic [7:0] a);
    is_set = (a[7:6] == `VSV_SET_TAG);
  endfunction

  // threshold code in 0.01 un to magnitude in 0.001 un
  function automatic logic [15:0] thr_mag(input logic [6:0] c);
    thr_mag = {9'h000, c} * `VSV_THR_SCALE;
  endfunction

  // shortest distance between two angles in 0.1 deg
  function automatic logic [11:0] ang_dist(input logic [11:0] a, input logic [11:0] b);
    logic [11:0] d;
    d = (a >= b) ? a - b : b - a;
    ang_dist = (d > `VSV_ANG_HALF) ? `VSV_ANG_FULL - d : d;
  endfunction

  ////////////////////////////////////////////////////////////////
  // ahb-lite slave
  logic dp_valid_r;
  logic dp_write_r;
  logic [7:0] dp_addr_r;
  logic [31:0] rd_r;
  logic [1:0] ctrl_r;
  logic [63:0] mem_a;
  logic [63:0] mem_b;
  logic [1:0] mem_we;
  logic wr_ctrl;
  logic cnt_clr;
  logic [31:0] rd_nxt;
  wire ap = I_HSEL & I_HREADY & I_HTRANS[1];

  // address phase capture
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r <= 8'h0;
    end else begin
      dp_valid_r <= ap;
      dp_write_r <= I_HWRITE;
      dp_addr_r <= I_HADDR[7:0];
    end
  end

  // write strobes in the data phase
  assign wr_ctrl = dp_valid_r & dp_write_r & (dp_addr_r == `VSV_CTRL_OFS);
  assign cnt_clr = wr_ctrl & I_HWDATA[`VSV_CTRL_CLR];
  assign mem_we[0] = dp_valid_r & dp_write_r & is_set(dp_addr_r) & ~dp_addr_r[2];
  assign mem_we[1] = dp_valid_r & dp_write_r & is_set(dp_addr_r) & dp_addr_r[2];

  // stage forcing control
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      ctrl_r <= 2'h0;
    end else if (wr_ctrl) begin
      ctrl_r <= {I_HWDATA[`VSV_CTRL_FORCE], 1'b0};
    end
  end

  // settings of all groups, port b follows the active group
  vsv_setmem u_mem (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_we(mem_we),
    .i_waddr(dp_addr_r[5:3]),
    .i_wdata(I_HWDATA),
    .i_raddr_a(I_HADDR[5:3]),
    .o_rdata_a(mem_a),
    .i_raddr_b(I_GROUP_SEL),
    .o_rdata_b(mem_b)
  );

  vsv_pkg::vsv_cfg_t cfg;
  logic [15:0] delay;
  logic [15:0] low_mag;
  logic [15:0] high_mag;
  assign cfg = vsv_pkg::vsv_cfg_t'(mem_b[27:0]);
  assign delay = mem_b[47:32];
  assign low_mag = thr_mag(cfg.low_thr);
  assign high_mag = thr_mag(cfg.high_thr);

  ////////////////////////////////////////////////////////////////
  // threshold comparators per phase
  logic [2:0] below;
  logic [2:0] above;
  logic [2:0] ablk;
  logic [2:0] below_r;
  logic [2:0] above_r;
  logic [15:0] ratio_r [3];

  for (genvar p = 0; p < 3; p++) begin : g_ph
    logic [7:0][11:0] hist_r;
    logic [23:0] quot;
    wire [15:0] mag = cfg.ch_line ? I_MEAS.ll_rms[p] : I_MEAS.ph_rms[p];
    wire [11:0] ang = cfg.ch_line ? I_MEAS.ll_ang[p] : I_MEAS.ph_ang[p];
    assign below[p] = mag < low_mag;
    assign above[p] = mag > high_mag;
    assign ablk[p] = ang_dist(ang, hist_r[7]) < {2'h0, cfg.ang_lim};
    assign quot = {low_mag, 8'h00} / {8'h00, mag};
    // angle history, oldest entry is eight ticks back
    always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
        hist_r <= '0;
      end else if (I_MEAS_TICK) begin
        hist_r <= {hist_r[6:0], ang};
      end
    end
    // ratio in 8.8 fixed point, saturated
    always_ff @(posedge I_CLOCK) begin
      if (I_RST) begin
        ratio_r[p] <= 16'h0;
      end else if (I_MEAS_TICK) begin
        ratio_r[p] <= (mag == 16'h0 || |quot[23:16]) ? 16'hffff : quot[15:0];
      end
    end
  end

  // voltage pick-up and sequence flags, once per tick
  logic volt_pick_r;
  logic pos_hi_r;
  logic pos_lo_r;
  logic neg_hi_r;
  logic neg_lo_r;
  wire two_above = (above[0] & above[1]) | (above[1] & above[2]) | (above[0] & above[2]);
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      volt_pick_r <= 1'b0;
      below_r <= 3'h0;
      above_r <= 3'h0;
      {pos_hi_r, pos_lo_r, neg_hi_r, neg_lo_r} <= 4'h0;
    end else if (I_MEAS_TICK) begin
      volt_pick_r <= cfg.enable & ((|below) | two_above) & ~(&ablk);
      below_r <= below;
      above_r <= above;
      pos_hi_r <= I_MEAS.positive_seq_voltage > high_mag;
      pos_lo_r <= I_MEAS.positive_seq_voltage < low_mag;
      neg_hi_r <= I_MEAS.negative_seq_voltage > high_mag;
      neg_lo_r <= I_MEAS.negative_seq_voltage < low_mag;
    end
  end

  ////////////////////////////////////////////////////////////////
  // fuse inputs, pick-up, blocking
  logic bus_fuse;
  logic line_fuse;
  logic pickup;
  logic blk;
  logic start_r;
  logic blocked_r;
  logic start_nxt;
  assign bus_fuse = cfg.enable & cfg.bus_chk & I_BUS_BREAKER_TRIP_INPUT;
  assign line_fuse = cfg.enable & cfg.line_chk & I_FEEDER_BREAKER_TRIP_INPUT;
  assign pickup = volt_pick_r | bus_fuse | line_fuse;
  assign blk = I_BLOCK | ctrl_r[1];
  assign start_nxt = pickup & ~blk;

  // start and blocked, re-evaluated on every clock
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      start_r <= 1'b0;
      blocked_r <= 1'b0;
    end else begin
      start_r <= start_nxt;
      blocked_r <= pickup & blk;
    end
  end

  ////////////////////////////////////////////////////////////////
  // definite-time delay in measurement ticks
  vsv_pkg::vsv_tmr_t st_r;
  logic [15:0] tmr_r;
  logic bus_alarm_r;
  logic line_alarm_r;
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      st_r <= vsv_pkg::T_IDLE;
      tmr_r <= 16'h0;
    end else begin
      case (st_r)
        vsv_pkg::T_IDLE: begin
          tmr_r <= 16'h0;
          if (start_r) begin
            st_r <= (delay == 16'h0) ? vsv_pkg::T_ALARM : vsv_pkg::T_RUN;
          end
        end
        vsv_pkg::T_RUN: begin
          if (!start_r) begin
            st_r <= vsv_pkg::T_IDLE;
          end else if (I_MEAS_TICK) begin
            tmr_r <= tmr_r + 16'h1;
            if (tmr_r + 16'h1 >= delay) begin
              st_r <= vsv_pkg::T_ALARM;
            end
          end
        end
        vsv_pkg::T_ALARM: begin
          if (!start_r) begin
            st_r <= vsv_pkg::T_IDLE;
          end
        end
        default: begin
          st_r <= vsv_pkg::T_IDLE;
        end
      endcase
    end
  end

  // alarms follow their source while the delay has run out
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      bus_alarm_r <= 1'b0;
      line_alarm_r <= 1'b0;
    end else begin
      bus_alarm_r <= (st_r == vsv_pkg::T_ALARM) & start_r & (volt_pick_r | bus_fuse);
      line_alarm_r <= (st_r == vsv_pkg::T_ALARM) & start_r & line_fuse;
    end
  end

  ////////////////////////////////////////////////////////////////
  // pre-fault average of positive sequence voltage
  logic [7:0][15:0] pos_hist_r;
  logic [15:0] pref_r;
  logic [17:0] pref_sum;
  assign pref_sum = {2'h0, pos_hist_r[3]} + {2'h0, pos_hist_r[4]} + {2'h0, pos_hist_r[5]} + {2'h0, pos_hist_r[6]};
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      pos_hist_r <= '0;
    end else if (I_MEAS_TICK) begin
      pos_hist_r <= {pos_hist_r[6:0], I_MEAS.positive_seq_voltage};
    end
  end
  // latched on the rising edge of start
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      pref_r <= 16'h0;
    end else if (start_nxt & ~start_r) begin
      pref_r <= pref_sum[17:2];
    end
  end

  ////////////////////////////////////////////////////////////////
  // condition code and bus state
  vsv_pkg::vsv_cond_t cond_r;
  vsv_pkg::vsv_bus_t bus_r;
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      cond_r <= vsv_pkg::COND_NORMAL;
    end else if (blocked_r) begin
      cond_r <= vsv_pkg::COND_BLOCKED;
    end else if (bus_alarm_r) begin
      cond_r <= vsv_pkg::COND_BUS;
    end else if (line_alarm_r) begin
      cond_r <= vsv_pkg::COND_LINE;
    end else if (start_r) begin
      cond_r <= vsv_pkg::COND_START;
    end else begin
      cond_r <= vsv_pkg::COND_NORMAL;
    end
  end

  // dead first, then problem, then the sequence verdict
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      bus_r <= vsv_pkg::BUS_DEAD;
    end else if (&below_r) begin
      bus_r <= vsv_pkg::BUS_DEAD;
    end else if (pickup) begin
      bus_r <= vsv_pkg::BUS_PROBLEM;
    end else if (pos_hi_r & neg_lo_r) begin
      bus_r <= vsv_pkg::BUS_OK;
    end else if (neg_hi_r & pos_lo_r) begin
      bus_r <= vsv_pkg::BUS_REV;
    end else begin
      bus_r <= vsv_pkg::BUS_UNDEF;
    end
  end

  ////////////////////////////////////////////////////////////////
  // events and counters
  logic [3:0][15:0] cnt;
  vsv_pkg::vsv_outs_t outs;
  assign outs = '{blocked: blocked_r, line_alarm: line_alarm_r, bus_alarm: bus_alarm_r, start: start_r};
  vsv_events #(
    .MS_CYCLES(MS_CYCLES)
  ) u_evt (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_outs(outs),
    .i_cnt_clr(cnt_clr),
    .o_evt_valid(O_EVT_VALID),
    .o_evt(O_EVT),
    .o_cnt(cnt)
  );

  ////////////////////////////////////////////////////////////////
  // read data, prepared in the address phase
  always_comb begin
    case (I_HADDR[7:0])
      `VSV_CTRL_OFS: rd_nxt = {30'h0, ctrl_r};
      `VSV_STAT_OFS: rd_nxt = {18'h0, pickup, I_GROUP_SEL, outs, bus_r, cond_r};
      `VSV_CNT0_OFS: rd_nxt = {cnt[1], cnt[0]};
      `VSV_CNT1_OFS: rd_nxt = {cnt[3], cnt[2]};
      `VSV_RAT0_OFS: rd_nxt = {ratio_r[1], ratio_r[0]};
      `VSV_RAT1_OFS: rd_nxt = {16'h0, ratio_r[2]};
      `VSV_PREF_OFS: rd_nxt = {16'h0, pref_r};
      `VSV_TREM_OFS: rd_nxt = {16'h0, delay - tmr_r};
      default: rd_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      rd_r <= 32'h0;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  assign O_HRDATA = is_set(dp_addr_r) ? (dp_addr_r[2] ? mem_a[63:32] : mem_a[31:0]) : rd_r;
  assign O_HREADYOUT = 1'b1; // zero wait states
  assign O_HRESP = 1'b0;
  assign O_START = start_r;
  assign O_BUS_ALARM = bus_alarm_r;
  assign O_LINE_ALARM = line_alarm_r;
  assign O_BLOCKED = blocked_r;
  assign O_CONDITION = cond_r;
  assign O_BUS_STATE = bus_r;
endmodule

//--- test/vsv_top_props.sv
// concurrent checks on the vt supervision top-level ports
`timescale 1ns/1ps
module vsv_top_props #(
  parameter int MS_CYCLES = 10
) (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_BLOCK,
  input wire logic O_START,
  input wire logic O_BUS_ALARM,
  input wire logic O_LINE_ALARM,
  input wire logic O_BLOCKED,
  input wire logic O_EVT_VALID,
  input wire vsv_pkg::vsv_event_t O_EVT,
  input wire logic [2:0] O_CONDITION
);
  logic [3:0] outs;
  // the four outputs in event bit order, start in bit 0
  assign outs = {O_BLOCKED, O_LINE_ALARM, O_BUS_ALARM, O_START};
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RST);
  ////////////////////////////////////////////////////////////////////////////
  // start rising, then its event word one edge later
  sequence s_start_up;
    !O_START ##1 O_START;
  endsequence
  sequence s_start_evt;
    O_EVT_VALID && O_EVT.rise[0];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_start_not_blocked: assert property (O_START |-> !O_BLOCKED)
    else $error("start and blocked high together");
  a_block_kills_start: assert property (I_BLOCK |=> !O_START)
    else $error("start survived a block request");
  a_start_event: assert property (s_start_up |=> s_start_evt)
    else $error("no rise event after start");
  a_evt_each_edge: assert property ($changed(outs) |=> O_EVT_VALID)
    else $error("output edge without event");
  a_evt_has_cause: assert property (O_EVT_VALID |-> $past(outs) != $past(outs, 2))
    else $error("event without output edge");
  a_evt_edge_bits: assert property (O_EVT_VALID |-> O_EVT.rise == ($past(outs) & ~$past(outs, 2))
    && O_EVT.fall == (~$past(outs) & $past(outs, 2)))
    else $error("event edge bits wrong");
  a_cond_blocked: assert property (O_BLOCKED [*3] |-> O_CONDITION == 3'h4)
    else $error("condition code not blocked");
  a_cond_bus: assert property ((O_START && O_BUS_ALARM && !O_LINE_ALARM) [*3] |-> O_CONDITION == 3'h3)
    else $error("condition code not bus alarm");
  a_alarm_needs_start: assert property ((O_BUS_ALARM || O_LINE_ALARM)
    |-> O_START || $past(O_START) || $past(O_START, 2))
    else $error("alarm without start");
  // the millisecond stamp only ever holds or steps by one
  a_stamp_steps: assert property (O_EVT.stamp_ms - $past(O_EVT.stamp_ms) <= 32'h1)
    else $error("event stamp jumped");
endmodule

bind vsv_top vsv_top_props #(.MS_CYCLES(MS_CYCLES)) vsv_top_props_inst (
  .I_CLOCK(I_CLOCK),
  .I_RST(I_RST),
  .I_BLOCK(I_BLOCK),
  .O_START(O_START),
  .O_BUS_ALARM(O_BUS_ALARM),
  .O_LINE_ALARM(O_LINE_ALARM),
  .O_BLOCKED(O_BLOCKED),
  .O_EVT_VALID(O_EVT_VALID),
  .O_EVT(O_EVT),
  .O_CONDITION(O_CONDITION)
);

//--- test/vsv_meas_model.sv
// measurement front end model: a fresh rms, positive sequence and angle set per tick
`timescale 1ns/1ps
module vsv_meas_model #(
  parameter int TICK = 50
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0][15:0] i_mag,
  input wire logic i_rot,
  output logic o_tick,
  output vsv_pkg::vsv_meas_t o_meas
);
  int cnt;
  logic [11:0] base;
  // angle in 0.1 deg folded back into one turn
  function automatic logic [11:0] wrap(input logic [12:0] x);
    return (x >= 13'h0e10) ? 12'(x - 13'h0e10) : x[11:0];
  endfunction
  // tick and new set land together; the set is held until the next tick
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt <= 0;
      base <= 12'h000;
      o_tick <= 1'b0;
      o_meas <= '0;
    end else begin
      o_tick <= (cnt == TICK - 1);
      cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
      if (cnt == TICK - 1) begin
        base <= i_rot ? wrap({1'b0, base} + 13'h0064) : base;
        o_meas.ph_rms <= i_mag;
        o_meas.ll_rms <= i_mag;
        o_meas.positive_seq_voltage <= 16'(({2'h0, i_mag[0]} + {2'h0, i_mag[1]} + {2'h0, i_mag[2]}) / 18'h3);
        for (int k = 0; k < 3; k++) begin
          o_meas.ph_ang[k] <= wrap({1'b0, base} + 13'(k) * 13'h04b0);
          o_meas.ll_ang[k] <= wrap({1'b0, base} + 13'(k) * 13'h04b0);
        end
      end
    end
  end
endmodule

//--- test/voltage_transformer_supervision_bench.sv
// self-checking bench for the vt supervision block
`timescale 1ns/1ps
module voltage_transformer_supervision_bench;
  localparam logic [15:0] nv = 16'h01f4;
  localparam logic [15:0] lv = 16'h0028;
  localparam logic [15:0] bv = 16'h0032;
  localparam logic [15:0] hv = 16'h0384;
  localparam logic [15:0] ev = 16'h0320;
  typedef struct packed {logic [2:0][15:0] mag; logic [2:0] src; logic [3:0] outs; logic [2:0] cond;
    logic [2:0] bst;} vsv_row_t;
  // src is {block, line fuse, bus fuse}; outs is {blocked, line, bus, start}
  vsv_row_t rows [13] = '{'{'{nv, nv, nv}, 3'h0, 4'h0, 3'h0, 3'h3}, '{'{lv, nv, nv}, 3'h0, 4'h1, 3'h1, 3'h4},
    '{'{nv, hv, nv}, 3'h0, 4'h0, 3'h0, 3'h3}, '{'{nv, hv, hv}, 3'h0, 4'h1, 3'h1, 3'h4},
    '{'{bv, nv, nv}, 3'h0, 4'h0, 3'h0, 3'h3}, '{'{ev, ev, ev}, 3'h0, 4'h0, 3'h0, 3'h3},
    '{'{nv, nv, nv}, 3'h1, 4'h1, 3'h1, 3'h4}, '{'{nv, nv, nv}, 3'h0, 4'h0, 3'h0, 3'h3},
    '{'{nv, nv, nv}, 3'h2, 4'h1, 3'h1, 3'h4}, '{'{nv, nv, nv}, 3'h0, 4'h0, 3'h0, 3'h3},
    '{'{lv, nv, nv}, 3'h4, 4'h8, 3'h4, 3'h4}, '{'{nv, nv, nv}, 3'h4, 4'h0, 3'h0, 3'h3},
    '{'{ev, ev, 16'hffff}, 3'h0, 4'h0, 3'h0, 3'h1}};
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, blk = 1'b0, bf = 1'b0, lf = 1'b0, rot = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, grp = 3'h0, cond, bst;
  logic [2:0][15:0] mag = {nv, nv, nv};
  logic hready, hresp, tick, start, bal, lal, blkd, evv, prv = 1'b0;
  vsv_pkg::vsv_meas_t meas;
  vsv_pkg::vsv_event_t evt;
  int n_errors = 0, n_tests = 0, cycles = 0, nst = 0;
  vsv_meas_model #(.TICK(50)) vsv_meas_model_inst (.i_clk(clk), .i_rst(rst), .i_mag(mag), .i_rot(rot),
    .o_tick(tick), .o_meas(meas));
  vsv_top #(.MS_CYCLES(10)) vsv_top_inst (.I_CLOCK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_MEAS_TICK(tick), .I_MEAS(meas),
    .I_GROUP_SEL(grp), .I_BLOCK(blk), .I_BUS_BREAKER_TRIP_INPUT(bf), .I_FEEDER_BREAKER_TRIP_INPUT(lf),
    .O_START(start), .O_BUS_ALARM(bal), .O_LINE_ALARM(lal), .O_BLOCKED(blkd), .O_EVT_VALID(evv), .O_EVT(evt),
    .O_CONDITION(cond), .O_BUS_STATE(bst));
  // 200 mhz clock
  always #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // outputs are looked at mid-cycle, where they are settled
  task automatic chk_pins(input logic [3:0] o, input logic [2:0] c, input logic [2:0] b);
    @(negedge clk);
    chk({21'h0, hresp, blkd, lal, bal, start, cond, bst}, {22'h0, o, c, b});
    @(posedge clk);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one ahb-lite single word transfer; entered and left just after an edge
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
    logic ok;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do begin
      @(negedge clk);
      ok = hready;
      @(posedge clk);
    end while (ok !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(negedge clk);
      ok = hready;
      r = hrdata;
      @(posedge clk);
    end while (ok !== 1'b1);
  endtask
  // a hang ends the run as a failure
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      n_errors++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(10);
    rst <= 1'b0;
    cyc(2);
    ahb(1'b0, 32'h40, 32'h0, rd);
    chk(rd, 32'h0b0ca805);
    ahb(1'b0, 32'h7c, 32'h0, rd);
    chk(rd, 32'h00000014);
    ahb(1'b1, 32'h20, 32'hffffffff, rd);
    ahb(1'b0, 32'h20, 32'h0, rd);
    chk(rd, 32'h0);
    cyc(600);
    ahb(1'b1, 32'h0, 32'h1, rd);
    foreach (rows[i]) begin
      mag <= rows[i].mag;
      {blk, lf, bf} <= rows[i].src;
      cyc(160);
      if (rows[i].outs[0] && !prv) nst++;
      prv = rows[i].outs[0];
      chk_pins(rows[i].outs, rows[i].cond, rows[i].bst);
    end
    blk <= 1'b0;
    ahb(1'b0, 32'h08, 32'h0, rd);
    chk(rd, nst);
    ahb(1'b0, 32'h0c, 32'h0, rd);
    chk(rd, 32'h00010000);
    ahb(1'b1, 32'h0, 32'h1, rd);
    ahb(1'b0, 32'h08, 32'h0, rd);
    chk(rd, 32'h0);
    mag <= {ev, ev, ev};
    cyc(160);
    ahb(1'b0, 32'h10, 32'h0, rd);
    chk(rd, 32'h00100010);
    ahb(1'b0, 32'h14, 32'h0, rd);
    chk(rd, 32'h00000010);
    ahb(1'b1, 32'h48, 32'h0b0cb205, rd);
    ahb(1'b0, 32'h48, 32'h0, rd);
    chk(rd, 32'h0b0cb205);
    mag <= {nv, hv, hv};
    grp <= 3'h1;
    cyc(160);
    chk_pins(4'h0, 3'h0, 3'h3);
    grp <= 3'h0;
    cyc(160);
    chk_pins(4'h1, 3'h1, 3'h4);
    mag <= {nv, nv, nv};
    ahb(1'b1, 32'h40, 32'h0a0ca805, rd);
    bf <= 1'b1;
    cyc(120);
    chk_pins(4'h0, 3'h0, 3'h3);
    bf <= 1'b0;
    ahb(1'b1, 32'h40, 32'h0b0ca805, rd);
    cyc(400);
    bf <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk({31'h0, start}, 32'h1);
    @(posedge clk);
    bf <= 1'b0;
    // steady nominal history, so the pre-fault average is the nominal value
    ahb(1'b0, 32'h18, 32'h0, rd);
    chk(rd, {16'h0, nv});
    ahb(1'b1, 32'h44, 32'h2, rd);
    mag <= {lv, nv, nv};
    cyc(400);
    chk_pins(4'h3, 3'h3, 3'h4);
    mag <= {nv, nv, nv};
    cyc(160);
    chk_pins(4'h0, 3'h0, 3'h3);
    lf <= 1'b1;
    cyc(400);
    chk_pins(4'h5, 3'h2, 3'h4);
    ahb(1'b1, 32'h0, 32'h2, rd);
    cyc(20);
    chk_pins(4'h8, 3'h4, 3'h4);
    ahb(1'b0, 32'h0, 32'h0, rd);
    chk(rd, 32'h2);
    ahb(1'b1, 32'h0, 32'h0, rd);
    lf <= 1'b0;
    rot <= 1'b0;
    cyc(600);
    mag <= {lv, nv, nv};
    cyc(160);
    @(negedge clk);
    chk({28'h0, blkd, lal, bal, start}, 32'h0);
    @(posedge clk);
    // mid-run reset: outputs idle, bus dead, changed group back to defaults
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    chk_pins(4'h0, 3'h0, 3'h0);
    ahb(1'b0, 32'h48, 32'h0, rd);
    chk(rd, 32'h0b0ca805);
    end_of_test();
  end
endmodule
